// >>> bsc_pkg.sv
// ****************************************************************************
// Shared constants and types; the sweep-time step converter is its own module.
// ****************************************************************************
package bsc_pkg;

  localparam int SPAN_W = 29;
  localparam int BW_W   = 4;
  localparam int STEP_W = 5;
  localparam int ST_W   = 24;

  // Span is carried in units of 0.1 Hz.
  localparam logic [SPAN_W-1:0] SPAN_RESET = 29'h17d7_8400;
  localparam logic [SPAN_W-1:0] SPAN_MAX   = 29'h17e6_c640;

  // Lower edges of the span bands; band k starts at SPAN_EDGE[k].
  localparam logic [SPAN_W-1:0] SPAN_EDGE [8] = '{
    29'h0000_07d0, 29'h0000_2710, 29'h0000_c350, 29'h0003_0d40,
    29'h000f_4240, 29'h004c_4b40, 29'h0131_2d00, 29'h05f5_e100
  };

  // Bandwidth index in the 1, 3, 10 sequence: 0 is 1 Hz, 9 is 30 kHz.
  localparam int              BW_VBW_MIN = 0;
  localparam int              BW_RBW_MIN = 1;
  localparam int              BW_MAX     = 9;
  localparam logic [BW_W-1:0] BW_RESET   = 4'h9;

  localparam int STEP_MAX = 15;
  localparam int STEP_MIN = -15;

  // Sweep time is carried in units of 1 ms.
  localparam int              ST_UNIT_MS = 1;
  localparam int              ST_MIN_MS  = 200;
  localparam logic [ST_W-1:0] ST_MIN     = ST_W'(ST_MIN_MS / ST_UNIT_MS);

  typedef struct packed {
    logic              inst_preset;
    logic              coupling_preset;
    logic              couple_toggle;
    logic              hold_toggle;
    logic              span_load;
    logic [SPAN_W-1:0] span_value;
    logic              rbw_up;
    logic              rbw_down;
    logic              rbw_load;
    logic [BW_W-1:0]   rbw_value;
    logic              vbw_up;
    logic              vbw_down;
    logic              vbw_load;
    logic [BW_W-1:0]   vbw_value;
    logic              st_up;
    logic              st_down;
    logic              st_load;
    logic [ST_W-1:0]   st_value;
  } bsc_cmd_s;

  typedef struct packed {
    logic [SPAN_W-1:0] span;
    logic [BW_W-1:0]   rbw;
    logic [BW_W-1:0]   vbw;
    logic [ST_W-1:0]   sweep_time;
  } bsc_setting_s;

endpackage

// >>> bsc_st_convert.sv
`timescale 1ns/10ps
`default_nettype none
// ****************************************************************************
// Converts an entered sweep time into the nearest whole power-of-two step.
// ****************************************************************************
module bsc_st_convert (
  input  wire logic [bsc_pkg::ST_W-1:0]          entered,
  input  wire logic [bsc_pkg::ST_W-1:0]          optimum,
  output logic signed [bsc_pkg::STEP_W-1:0]      steps
);

  localparam int SQ_W = 2 * bsc_pkg::ST_W + 2 * bsc_pkg::STEP_MAX + 2;

  logic [SQ_W-1:0]          sq_entered;
  logic [SQ_W-1:0]          sq_optimum;
  logic [bsc_pkg::STEP_W-1:0] up_count;
  logic [bsc_pkg::STEP_W-1:0] down_count;

  // Comparing squares against odd powers of two places the rounding
  // thresholds at half steps without any logarithm hardware.
  always_comb begin
    sq_entered = SQ_W'(entered) * SQ_W'(entered);
    sq_optimum = SQ_W'(optimum) * SQ_W'(optimum);
    up_count   = '0;
    down_count = '0;
    for (int k = 0; k < bsc_pkg::STEP_MAX; k++) begin
      if (sq_entered >= (sq_optimum << (2 * k + 1))) begin
        up_count = up_count + 5'h1;
      end
      if ((sq_entered << (2 * k + 1)) <= sq_optimum) begin
        down_count = down_count + 5'h1;
      end
    end
    if (optimum == '0) begin
      steps = '0;
    end else begin
      steps = $signed(up_count - down_count);
    end
  end

endmodule // bsc_st_convert
`default_nettype wire

// >>> bsc_coupling.sv
`timescale 1ns/10ps
`default_nettype none
// Function
// - Coupled: RBW change recomputes VBW; VBW change never touches RBW.
// - Coupled: RBW follows span; bandwidth changes never alter span.
// - Span bands map to optimum RBW/VBW pairs from 3/10 Hz to 30k/30k.
// - RBW offset from optimum is stored and reapplied after each span change.
// - Coupled RBW clamps to 3 Hz..30 kHz; stored offset survives clamping.
// - VBW offset from its optimum is kept; VBW clamps to 1 Hz..30 kHz.
// - Hold stops span-driven bandwidth changes and preset of RBW; entries still work.
// - Optimum sweep time follows span and bandwidths; never changes them back.
// - Optimized sweep time never goes below 0.2 seconds.
// - Uncalibrated flag is high exactly when applied sweep time is below optimum.
// - Stepped sweep time is a signed step count kept across other changes.
// - Numeric sweep time holds until span or bandwidth change, then becomes steps.
// - Applied sweep time is the optimum times two to the step count.
// - Conversion rounds log2 of entered over optimum to nearest integer.
// - Coupling preset clears VBW and sweep offsets; RBW kept under hold.
// - Instrument reset: coupled, no hold, 40 MHz span, 30 kHz bandwidths, 0.2 s.
// - Bandwidths step through a 1, 3, 10 sequence within their ranges.
module bsc_coupling (
  input  wire logic                                 clk_sys,
  input  wire logic                                 reset_n,
  input  wire bsc_pkg::bsc_cmd_s                    cmd,
  input  wire logic [bsc_pkg::ST_W-1:0]             opt_sweep_time_raw,
  output bsc_pkg::bsc_setting_s                     setting,
  output logic [bsc_pkg::ST_W-1:0]                  opt_sweep_time,
  output logic                                      uncal,
  output logic                                      coupled,
  output logic                                      resolution_hold,
  output logic                                      optimized,
  output logic signed [bsc_pkg::STEP_W-1:0]         rbw_offset,
  output logic signed [bsc_pkg::STEP_W-1:0]         vbw_offset,
  output logic signed [bsc_pkg::STEP_W-1:0]         st_offset,
  output logic                                      st_numeric
);

  // **************************************************************************
  // Helper functions.
  // **************************************************************************

  function automatic logic [bsc_pkg::BW_W-1:0] opt_rbw(
    input logic [bsc_pkg::SPAN_W-1:0] span_in
  );
    logic [bsc_pkg::BW_W-1:0] idx;
    idx = 4'h1;
    for (int k = 0; k < 8; k++) begin
      if (span_in >= bsc_pkg::SPAN_EDGE[k]) begin
        idx = idx + 4'h1;
      end
    end
    return idx;
  endfunction

  // Optimum VBW is one position above RBW, with 30 kHz as the top.
  function automatic logic [bsc_pkg::BW_W-1:0] opt_vbw(
    input logic [bsc_pkg::BW_W-1:0] rbw_in
  );
    if (int'(rbw_in) >= bsc_pkg::BW_MAX) begin
      return bsc_pkg::BW_W'(bsc_pkg::BW_MAX);
    end
    return rbw_in + 4'h1;
  endfunction

  function automatic logic [bsc_pkg::BW_W-1:0] clamp_bw(input int v, input int lo);
    if (v < lo) begin
      return bsc_pkg::BW_W'(lo);
    end
    if (v > bsc_pkg::BW_MAX) begin
      return bsc_pkg::BW_W'(bsc_pkg::BW_MAX);
    end
    return bsc_pkg::BW_W'(v);
  endfunction

  function automatic logic signed [bsc_pkg::STEP_W-1:0] sat_step(input int v);
    if (v < bsc_pkg::STEP_MIN) begin
      return bsc_pkg::STEP_W'(bsc_pkg::STEP_MIN);
    end
    if (v > bsc_pkg::STEP_MAX) begin
      return bsc_pkg::STEP_W'(bsc_pkg::STEP_MAX);
    end
    return bsc_pkg::STEP_W'(v);
  endfunction

  // Multiplies by two to the signed step count, saturating at the top.
  function automatic logic [bsc_pkg::ST_W-1:0] scale_st(
    input logic [bsc_pkg::ST_W-1:0]          base,
    input logic signed [bsc_pkg::STEP_W-1:0] n
  );
    logic [bsc_pkg::ST_W+bsc_pkg::STEP_MAX-1:0] wide;
    wide = '0;
    if (n >= 0) begin
      wide = (bsc_pkg::ST_W + bsc_pkg::STEP_MAX)'(base) << n;
      if (wide[bsc_pkg::ST_W+bsc_pkg::STEP_MAX-1:bsc_pkg::ST_W] != '0) begin
        return '1;
      end
      return wide[bsc_pkg::ST_W-1:0];
    end
    return base >> (-n);
  endfunction

  // **************************************************************************
  // State.
  // **************************************************************************

  logic [bsc_pkg::SPAN_W-1:0]         span;
  logic [bsc_pkg::BW_W-1:0]           rbw;
  logic [bsc_pkg::BW_W-1:0]           vbw;
  logic [bsc_pkg::ST_W-1:0]           st_entry;
  logic [bsc_pkg::ST_W-1:0]           sweep_time;

  logic [bsc_pkg::SPAN_W-1:0]         next_span;
  logic [bsc_pkg::BW_W-1:0]           next_rbw;
  logic [bsc_pkg::BW_W-1:0]           next_vbw;
  logic signed [bsc_pkg::STEP_W-1:0]  next_rbw_offset;
  logic signed [bsc_pkg::STEP_W-1:0]  next_vbw_offset;
  logic signed [bsc_pkg::STEP_W-1:0]  next_st_offset;
  logic                               next_st_numeric;
  logic [bsc_pkg::ST_W-1:0]           next_st_entry;
  logic                               next_coupled;
  logic                               next_resolution_hold;
  logic [bsc_pkg::ST_W-1:0]           next_sweep_time;
  logic [bsc_pkg::ST_W-1:0]           next_opt_sweep_time;
  logic                               next_uncal;

  logic [bsc_pkg::ST_W-1:0]           opt_st_now;
  logic signed [bsc_pkg::STEP_W-1:0]  conv_steps;
  logic                               rbw_event;
  logic                               vbw_event;
  logic                               st_event;
  logic                               rbw_changed;
  logic                               bw_span_changed;

  // **************************************************************************
  // Sweep-time conversion.
  // **************************************************************************

  // The optimum from the sweep calculator is floored before any use.
  always_comb begin
    if (opt_sweep_time_raw < bsc_pkg::ST_MIN) begin
      opt_st_now = bsc_pkg::ST_MIN;
    end else begin
      opt_st_now = opt_sweep_time_raw;
    end
  end

  bsc_st_convert u_convert (
    .entered (st_entry),
    .optimum (opt_st_now),
    .steps   (conv_steps)
  );

  assign rbw_event = cmd.rbw_up | cmd.rbw_down | cmd.rbw_load;
  assign vbw_event = cmd.vbw_up | cmd.vbw_down | cmd.vbw_load;
  assign st_event  = cmd.st_up | cmd.st_down | cmd.st_load;

  // **************************************************************************
  // Next-state logic. Priority: instrument preset, coupling preset, span,
  // RBW, VBW, sweep time; one entry is taken per cycle, plus any toggle unless a preset wins.
  // **************************************************************************

  always_comb begin
    next_span            = span;
    next_rbw             = rbw;
    next_vbw             = vbw;
    next_rbw_offset      = rbw_offset;
    next_vbw_offset      = vbw_offset;
    next_st_offset       = st_offset;
    next_st_numeric      = st_numeric;
    next_st_entry        = st_entry;
    next_coupled         = coupled;
    next_resolution_hold = resolution_hold;
    rbw_changed          = 1'b0;
    bw_span_changed      = 1'b0;
    if (cmd.inst_preset) begin
      next_coupled         = 1'b1;
      next_resolution_hold = 1'b0;
      next_span            = bsc_pkg::SPAN_RESET;
      next_rbw             = bsc_pkg::BW_RESET;
      next_vbw             = bsc_pkg::BW_RESET;
      next_rbw_offset      = '0;
      next_vbw_offset      = '0;
      next_st_offset       = '0;
      next_st_numeric      = 1'b0;
    end else if (cmd.coupling_preset) begin
      if (!resolution_hold) begin
        next_rbw        = opt_rbw(span);
        next_rbw_offset = '0;
      end
      next_vbw_offset = '0;
      next_vbw        = opt_vbw(next_rbw);
      next_st_offset  = '0;
      next_st_numeric = 1'b0;
    end else begin
      if (cmd.couple_toggle) begin
        next_coupled = ~coupled;
      end
      if (cmd.hold_toggle) begin
        next_resolution_hold = ~resolution_hold;
      end
      if (cmd.span_load) begin
        bw_span_changed = 1'b1;
        if (cmd.span_value > bsc_pkg::SPAN_MAX) begin
          next_span = bsc_pkg::SPAN_MAX;
        end else begin
          next_span = cmd.span_value;
        end
        if (coupled && !resolution_hold) begin
          next_rbw    = clamp_bw(int'(opt_rbw(next_span)) + int'(rbw_offset),
                                 bsc_pkg::BW_RBW_MIN);
          rbw_changed = 1'b1;
        end
      end else if (rbw_event) begin
        bw_span_changed = 1'b1;
        rbw_changed     = 1'b1;
        if (cmd.rbw_load) begin
          next_rbw = clamp_bw(int'(cmd.rbw_value), bsc_pkg::BW_RBW_MIN);
        end else if (cmd.rbw_up) begin
          next_rbw = clamp_bw(int'(rbw) + 1, bsc_pkg::BW_RBW_MIN);
        end else begin
          next_rbw = clamp_bw(int'(rbw) - 1, bsc_pkg::BW_RBW_MIN);
        end
        next_rbw_offset = sat_step(int'(next_rbw) - int'(opt_rbw(span)));
      end else if (vbw_event) begin
        bw_span_changed = 1'b1;
        if (cmd.vbw_load) begin
          next_vbw = clamp_bw(int'(cmd.vbw_value), bsc_pkg::BW_VBW_MIN);
        end else if (cmd.vbw_up) begin
          next_vbw = clamp_bw(int'(vbw) + 1, bsc_pkg::BW_VBW_MIN);
        end else begin
          next_vbw = clamp_bw(int'(vbw) - 1, bsc_pkg::BW_VBW_MIN);
        end
        next_vbw_offset = sat_step(int'(next_vbw) - int'(opt_vbw(rbw)));
      end else if (st_event) begin
        if (cmd.st_load) begin
          next_st_numeric = 1'b1;
          next_st_entry   = cmd.st_value;
        end else begin
          next_st_numeric = 1'b0;
          next_st_offset  = sat_step((st_numeric ? int'(conv_steps) : int'(st_offset))
                                     + (cmd.st_up ? 1 : -1));
        end
      end
      if (rbw_changed && coupled) begin
        next_vbw = clamp_bw(int'(opt_vbw(next_rbw)) + int'(vbw_offset),
                            bsc_pkg::BW_VBW_MIN);
      end
      if (bw_span_changed && st_numeric) begin
        next_st_offset  = conv_steps;
        next_st_numeric = 1'b0;
      end
    end
  end

  // Applied sweep time and its calibration flag.
  always_comb begin
    next_opt_sweep_time = opt_st_now;
    if (next_st_numeric) begin
      next_sweep_time = next_st_entry;
    end else begin
      next_sweep_time = scale_st(opt_st_now, next_st_offset);
    end
    next_uncal = (next_sweep_time < opt_st_now);
  end

  // **************************************************************************
  // Registers.
  // **************************************************************************

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      span            <= bsc_pkg::SPAN_RESET;
      rbw             <= bsc_pkg::BW_RESET;
      vbw             <= bsc_pkg::BW_RESET;
      rbw_offset      <= '0;
      vbw_offset      <= '0;
      st_offset       <= '0;
      st_numeric      <= 1'b0;
      st_entry        <= bsc_pkg::ST_MIN;
      coupled         <= 1'b1;
      resolution_hold <= 1'b0;
      sweep_time      <= bsc_pkg::ST_MIN;
      opt_sweep_time  <= bsc_pkg::ST_MIN;
      uncal           <= 1'b0;
    end else begin
      span            <= next_span;
      rbw             <= next_rbw;
      vbw             <= next_vbw;
      rbw_offset      <= next_rbw_offset;
      vbw_offset      <= next_vbw_offset;
      st_offset       <= next_st_offset;
      st_numeric      <= next_st_numeric;
      st_entry        <= next_st_entry;
      coupled         <= next_coupled;
      resolution_hold <= next_resolution_hold;
      sweep_time      <= next_sweep_time;
      opt_sweep_time  <= next_opt_sweep_time;
      uncal           <= next_uncal;
    end
  end

  assign setting.span       = span;
  assign setting.rbw        = rbw;
  assign setting.vbw        = vbw;
  assign setting.sweep_time = sweep_time;

  // Optimized means no offset is slipped and no numeric entry is pending.
  assign optimized = (rbw_offset == '0) && (vbw_offset == '0) && (st_offset == '0)
                     && !st_numeric;

endmodule // bsc_coupling
`default_nettype wire

// >>> bsc_checker.sv
`timescale 1ns/10ps
`default_nettype none
// ****************************************************************************
// Port-level checks of the coupling engine.
// ****************************************************************************
module bsc_checker (
  input wire logic                               clk_sys,
  input wire logic                               reset_n,
  input wire bsc_pkg::bsc_cmd_s                  cmd,
  input wire logic [bsc_pkg::ST_W-1:0]           opt_sweep_time_raw,
  input wire bsc_pkg::bsc_setting_s              setting,
  input wire logic [bsc_pkg::ST_W-1:0]           opt_sweep_time,
  input wire logic                               uncal,
  input wire logic                               coupled,
  input wire logic                               resolution_hold,
  input wire logic                               optimized,
  input wire logic signed [bsc_pkg::STEP_W-1:0]  rbw_offset,
  input wire logic signed [bsc_pkg::STEP_W-1:0]  vbw_offset,
  input wire logic signed [bsc_pkg::STEP_W-1:0]  st_offset,
  input wire logic                               st_numeric
);
  wire logic pre  = cmd.inst_preset | cmd.coupling_preset;
  wire logic tog  = cmd.couple_toggle | cmd.hold_toggle;
  wire logic rcmd = cmd.rbw_up | cmd.rbw_down | cmd.rbw_load;
  wire logic vcmd = cmd.vbw_up | cmd.vbw_down | cmd.vbw_load;
  wire logic scmd = cmd.st_up | cmd.st_down | cmd.st_load;
  wire logic span_only = cmd.span_load & !pre & !tog;
  wire logic st_only = scmd & !pre & !cmd.span_load & !rcmd & !vcmd;

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  AST_RESET_LOAD: assert property ($rose(reset_n) |-> setting.span == bsc_pkg::SPAN_RESET
    && setting.rbw == bsc_pkg::BW_RESET && setting.vbw == bsc_pkg::BW_RESET && coupled
    && !resolution_hold && setting.sweep_time == bsc_pkg::ST_MIN && optimized)
    else $error("reset values wrong");
  AST_ST_FLOOR: assert property ($past(reset_n) |-> opt_sweep_time ==
    (($past(opt_sweep_time_raw) < bsc_pkg::ST_MIN) ? bsc_pkg::ST_MIN : $past(opt_sweep_time_raw)))
    else $error("optimum sweep time not floored");
  AST_UNCAL: assert property ($past(reset_n) && $stable(setting.sweep_time)
    && $stable(opt_sweep_time) |-> uncal == (setting.sweep_time < opt_sweep_time))
    else $error("uncal flag wrong");
  AST_BW_RANGE: assert property (setting.rbw >= 4'h1 && setting.rbw <= 4'h9
    && setting.vbw <= 4'h9) else $error("bandwidth out of range");
  AST_SPAN_TAKEN: assert property (span_only |=> setting.span ==
    (($past(cmd.span_value) > bsc_pkg::SPAN_MAX) ? bsc_pkg::SPAN_MAX : $past(cmd.span_value)))
    else $error("span not taken");
  AST_HOLD_FREEZE: assert property (span_only && resolution_hold |=>
    $stable(setting.rbw) && $stable(setting.vbw)) else $error("hold let bandwidth move");
  AST_OFFSET_KEEP: assert property (span_only |=> $stable(rbw_offset)
    && $stable(vbw_offset)) else $error("span change altered offsets");
  AST_VBW_ONLY: assert property (vcmd && !pre && !cmd.span_load && !rcmd |=>
    $stable(setting.rbw) && $stable(setting.span)) else $error("vbw entry moved rbw");
  AST_ST_KEEPS: assert property (st_only |=> $stable(setting.span)
    && $stable(setting.rbw) && $stable(setting.vbw)) else $error("sweep entry moved others");
  AST_ST_ENTRY: assert property (st_only && cmd.st_load |=> st_numeric
    && setting.sweep_time == $past(cmd.st_value)) else $error("numeric sweep not applied");
  AST_PRESET: assert property (cmd.coupling_preset && !cmd.inst_preset |=>
    vbw_offset == 0 && st_offset == 0 && !st_numeric) else $error("preset left offsets");
  AST_POW2: assert property (!st_numeric && st_offset >= 0 && st_offset < 8 |->
    setting.sweep_time == (opt_sweep_time << st_offset)) else $error("sweep not power of two");

  COV_SPAN: cover property (span_only && coupled);
  COV_ST_LOAD: cover property (cmd.st_load);
  COV_HOLD_PRESET: cover property (cmd.coupling_preset && resolution_hold);
  COV_UNCAL: cover property (uncal);
endmodule // bsc_checker

bind bsc_coupling bsc_checker u_chk (
  .clk_sys(clk_sys), .reset_n(reset_n), .cmd(cmd), .opt_sweep_time_raw(opt_sweep_time_raw),
  .setting(setting), .opt_sweep_time(opt_sweep_time), .uncal(uncal), .coupled(coupled),
  .resolution_hold(resolution_hold), .optimized(optimized), .rbw_offset(rbw_offset),
  .vbw_offset(vbw_offset), .st_offset(st_offset), .st_numeric(st_numeric));
`default_nettype wire

// >>> bsc_sweep_model.sv
`timescale 1ns/10ps
`default_nettype none
// ****************************************************************************
// Sweep control model: works out the optimum sweep time from the settings.
// ****************************************************************************
module bsc_sweep_model (
  input  wire logic                      clk_sys,
  input  wire bsc_pkg::bsc_setting_s     setting,
  input  wire logic                      fixed_en,
  input  wire logic [bsc_pkg::ST_W-1:0]  fixed_ms,
  input  wire logic                      slow,
  output var logic [bsc_pkg::ST_W-1:0]   raw
);
  logic                     phase = 1'b0;
  logic [bsc_pkg::ST_W-1:0] formula;

  // Wider span or narrower bandwidths give a longer time; slow mode answers every other cycle.
  always_comb formula = (bsc_pkg::ST_W'(setting.span >> 13) >> setting.rbw)
                        + (24'h400 >> setting.vbw);
  always_ff @(posedge clk_sys) begin
    phase <= ~phase;
    if (!slow || phase) begin
      raw <= fixed_en ? fixed_ms : formula;
    end
  end
endmodule // bsc_sweep_model
`default_nettype wire

// >>> bsc_coupling_test.sv
`timescale 1ns/10ps
`default_nettype none
// ****************************************************************************
// Self-checking bench of the coupling engine.
// ****************************************************************************
module bsc_coupling_test;
  typedef enum {K_INST, K_CPRE, K_CTOG, K_HTOG, K_SPAN, K_RUP, K_RDN, K_VUP, K_VDN,
                K_SUP, K_SDN, K_RLD, K_VLD, K_SLD} bsc_key_e;
  logic                             clk_sys, reset_n, uncal, coupled, hold, optimized;
  logic                             st_numeric, fixed_en, slow;
  bsc_pkg::bsc_cmd_s                cmd;
  bsc_pkg::bsc_setting_s            setting;
  logic [bsc_pkg::ST_W-1:0]         raw, opt_st, fixed_ms;
  logic signed [bsc_pkg::STEP_W-1:0] rbw_off, vbw_off, st_off;
  int                               bad_count, check_count, cycles, seed, s, e_rbw, e_vbw, n;
  int                               opts[6] = '{2000, 200, 200, 800, 400, 1000};
  int                               ents[6] = '{3000, 10000, 8000, 2000, 300, 250};

  bsc_coupling DUT (.clk_sys(clk_sys), .reset_n(reset_n), .cmd(cmd), .opt_sweep_time_raw(raw),
    .setting(setting), .opt_sweep_time(opt_st), .uncal(uncal), .coupled(coupled),
    .resolution_hold(hold), .optimized(optimized), .rbw_offset(rbw_off),
    .vbw_offset(vbw_off), .st_offset(st_off), .st_numeric(st_numeric));
  bsc_sweep_model u_sweep (.clk_sys(clk_sys), .setting(setting), .fixed_en(fixed_en),
    .fixed_ms(fixed_ms), .slow(slow), .raw(raw));

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 6000) begin
      bad_count++;
      report_and_stop();
    end
  end

  function automatic int clampi(int x, int lo, int hi);
    return (x < lo) ? lo : (x > hi) ? hi : x;
  endfunction
  function automatic int opt_rbw(int sp);
    int r = 1;
    for (int k = 0; k < 8; k++) if (sp >= bsc_pkg::SPAN_EDGE[k]) r = k + 2;
    return clampi(r, 1, 9);
  endfunction
  function automatic int conv(int v, int o);
    return clampi(int'($ln(real'(v) / real'(o)) / $ln(2.0)), -15, 15);
  endfunction
  function automatic int pow2(int o, int k);
    return (k >= 0) ? (o << k) : (o >> -k);
  endfunction

  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic chk_bit(string what, logic exp, logic got);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic settle(int c);
    repeat (c) @(posedge clk_sys);
    #1;
  endtask
  task automatic key(bsc_key_e k, logic [31:0] v = '0);
    bsc_pkg::bsc_cmd_s c;
    c = '0;
    case (k)
      K_INST: c.inst_preset = 1'b1;
      K_CPRE: c.coupling_preset = 1'b1;
      K_CTOG: c.couple_toggle = 1'b1;
      K_HTOG: c.hold_toggle = 1'b1;
      K_SPAN: c.span_load = 1'b1;
      K_RUP: c.rbw_up = 1'b1;
      K_RDN: c.rbw_down = 1'b1;
      K_VUP: c.vbw_up = 1'b1;
      K_VDN: c.vbw_down = 1'b1;
      K_SUP: c.st_up = 1'b1;
      K_SDN: c.st_down = 1'b1;
      K_RLD: c.rbw_load = 1'b1;
      K_VLD: c.vbw_load = 1'b1;
      default: c.st_load = 1'b1;
    endcase
    c.span_value = v[28:0];
    c.st_value = v[23:0];
    c.rbw_value = v[3:0];
    c.vbw_value = v[3:0];
    @(posedge clk_sys);
    cmd <= c;
    @(posedge clk_sys);
    cmd <= '0;
    #1;
  endtask
  task automatic tdone(string name);
    $display("test %s done, %0d checks", name, check_count);
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    seed = 32'h85ab;
    cmd = '0;
    reset_n = 1'b0;
    fixed_en = 1'b0;
    fixed_ms = 24'h0000c8;
    slow = 1'b0;
    repeat (6) @(posedge clk_sys);
    reset_n <= 1'b1;
    #1;
    chk("span", bsc_pkg::SPAN_RESET, setting.span);
    chk("rbw", 9, setting.rbw);
    chk("sweep", 200, setting.sweep_time);
    chk_bit("coupled", 1'b1, coupled);
    tdone("reset");
    for (int i = 0; i < 36; i++) begin
      s = (i < 16) ? bsc_pkg::SPAN_EDGE[i/2] - 1 + i%2 : $unsigned($random(seed)) % 32'h1800_0000;
      key(K_SPAN, s);
      chk("span", (s > bsc_pkg::SPAN_MAX) ? bsc_pkg::SPAN_MAX : s, setting.span);
      chk("rbw", opt_rbw(s), setting.rbw);
      chk("vbw", clampi(opt_rbw(s) + 1, 0, 9), setting.vbw);
    end
    tdone("bands");
    key(K_SPAN, 32'h05f5_e100);
    key(K_RLD, 8);
    key(K_RDN);
    chk("vbw", 8, setting.vbw);
    key(K_VLD, 10);
    key(K_VDN);
    key(K_VUP);
    chk("rbw", 7, setting.rbw);
    for (int i = 0; i < 12; i++) begin
      s = (i == 0) ? 0 : (i == 1) ? 400000000 : $unsigned($random(seed)) % 32'h17d7_8400;
      key(K_SPAN, s);
      e_rbw = clampi(opt_rbw(s) - 2, 1, 9);
      e_vbw = clampi(clampi(e_rbw + 1, 0, 9) + 1, 0, 9);
      chk("rbw", e_rbw, setting.rbw);
      chk("rbw_off", -2, rbw_off);
      chk("vbw", e_vbw, setting.vbw);
      chk("vbw_off", 1, vbw_off);
    end
    tdone("offsets");
    key(K_HTOG);
    chk_bit("hold", 1'b1, hold);
    key(K_SPAN, 100);
    chk("rbw", e_rbw, setting.rbw);
    chk("vbw", e_vbw, setting.vbw);
    key(K_RUP);
    e_rbw = clampi(e_rbw + 1, 1, 9);
    chk("rbw", e_rbw, setting.rbw);
    key(K_CPRE);
    chk("rbw", e_rbw, setting.rbw);
    chk("vbw", clampi(e_rbw + 1, 0, 9), setting.vbw);
    chk("vbw_off", 0, vbw_off);
    key(K_HTOG);
    tdone("hold");
    fixed_en <= 1'b1;
    fixed_ms <= 24'h000032;
    settle(3);
    chk("opt", 200, opt_st);
    for (int i = 0; i < 12; i++) begin
      s = (i < 6) ? opts[i] : 200 + $unsigned($random(seed)) % 2800;
      n = (i < 6) ? ents[i] : 1 + $unsigned($random(seed)) % 100000;
      fixed_ms <= s[23:0];
      settle(3);
      key(K_CPRE);
      key(K_SLD, n);
      chk("sweep", n, setting.sweep_time);
      chk_bit("numeric", 1'b1, st_numeric);
      chk_bit("uncal", n < s, uncal);
      key(K_SPAN, 1000 + i);
      chk("st_off", conv(n, s), st_off);
      chk("sweep", pow2(s, conv(n, s)), setting.sweep_time);
    end
    tdone("numeric");
    fixed_ms <= 24'h00012c;
    settle(3);
    key(K_CPRE);
    key(K_SUP);
    key(K_SUP);
    chk("sweep", 1200, setting.sweep_time);
    slow <= 1'b1;
    fixed_ms <= 24'h0001f4;
    settle(5);
    chk("st_off", 2, st_off);
    chk("sweep", 2000, setting.sweep_time);
    for (int i = 0; i < 4; i++) key(K_SDN);
    settle(2);
    chk("sweep", 125, setting.sweep_time);
    chk_bit("uncal", 1'b1, uncal);
    tdone("steps");
    fixed_en <= 1'b0;
    key(K_SPAN, 32'h05f5_e100);
    key(K_CTOG);
    chk_bit("coupled", 1'b0, coupled);
    key(K_SPAN, 0);
    chk("rbw", 9, setting.rbw);
    key(K_INST);
    chk_bit("coupled", 1'b1, coupled);
    chk("span", bsc_pkg::SPAN_RESET, setting.span);
    chk("vbw", 9, setting.vbw);
    chk_bit("optimized", 1'b1, optimized);
    tdone("preset");
    report_and_stop();
  end
endmodule // bsc_coupling_test
`default_nettype wire
